// File: core/tw_pkg.sv
package tw_pkg;
  // Tape line and word geometry
  localparam int LINE_W = 3;
  localparam int WORD_W = 18;
  localparam int ADDR_W = 15;
  localparam int BLK_W = 12;
  localparam int MAX_BLOCKS = 4096;
  localparam logic [2:0] LINES_PER_WORD = 3'h6;
  localparam logic [2:0] LAST_LINE = 3'h5;
  // Interblock zone: lines and six-line control words
  localparam int IBZ_LINES = 30;
  localparam int IBZ_WORDS = IBZ_LINES / 6;

  // Mark codes as read in forward motion
  localparam logic [5:0] MK_CHECK = 6'h3B;
  localparam logic [5:0] MK_RCHECK = 6'h08;
  localparam logic [5:0] MK_DATA = 6'h38;
  localparam logic [5:0] MK_IBZ = 6'h15;
  localparam logic [5:0] MK_END = 6'h2D;
  localparam logic [5:0] MK_REND = 6'h12;
  localparam logic [5:0] MK_GUARD = 6'h29;
  localparam logic [5:0] MK_RGUARD = 6'h1A;
  localparam logic [5:0] MK_BLK = 6'h16;
  localparam logic [5:0] MK_RBLK = 6'h25;

  // Data channel zero cells
  localparam logic [ADDR_W-1:0] WC_CELL = 15'h001E;
  localparam logic [ADDR_W-1:0] CA_CELL = 15'h001F;

  // Word period on tape and clock rate
  localparam int WORD_US = 200;
  localparam int CLK_NS = 10;
  localparam int WORD_CYC = WORD_US * 1000 / CLK_NS;

  // Values after reset
  localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;
  localparam logic [5:0] CHK_SEED = 6'h00;
  localparam logic [2:0] LINE_RST = 3'h0;
  localparam logic [BLK_W-1:0] BLK_RST = 12'h000;

  // Operation modes on op_mode
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_SEARCH = 2'h1;
  localparam logic [1:0] MODE_READ = 2'h2;
  localparam logic [1:0] MODE_WRITE = 2'h3;

  typedef enum logic [2:0] {
    CH_IDLE, CH_RD_WC, CH_WR_WC, CH_RD_CA, CH_WR_CA, CH_DATA
  } tw_chan_e;

  typedef enum logic [1:0] {ZN_IBZ, ZN_DATA, ZN_CHECK} tw_zone_e;

  // One of the ten codes a mark frame may hold
  function automatic logic tw_legal(input logic [5:0] c);
    return c == MK_CHECK || c == MK_RCHECK || c == MK_DATA ||
      c == MK_IBZ || c == MK_END || c == MK_REND || c == MK_GUARD ||
      c == MK_RGUARD || c == MK_BLK || c == MK_RBLK;
  endfunction

  // Equivalence of the running check with each six-bit group
  function automatic logic [5:0] tw_chk_step(input logic [5:0] c,
                                             input logic [17:0] w);
    logic [5:0] t;
    t = ~(c ^ w[17:12]);
    t = ~(t ^ w[11:6]);
    return ~(t ^ w[5:0]);
  endfunction
endpackage

// File: core/tw_datapath.sv
`timescale 1ns/100ps
`default_nettype none
module tw_datapath #(
  parameter int WORD_CYC = tw_pkg::WORD_CYC
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Control from the processor side
  input wire logic [1:0] op_mode,
  input wire logic flag_clr,
  // Read amplifiers of the selected transport
  input wire logic timing_trk,
  input wire logic mark_trk,
  input wire logic [2:0] data_trk,
  // Write heads, one bit per data channel
  output logic [2:0] wr_cur,
  output logic wr_en,
  // Memory data channel
  output logic mem_req,
  output logic mem_we,
  output logic [14:0] mem_addr,
  output logic [17:0] mem_wdata,
  input wire logic [17:0] mem_rdata,
  input wire logic mem_ack,
  // Flags and status
  output logic word_request_flag,
  output logic block_boundary_flag,
  output logic mark_err,
  output logic check_err,
  output logic timing_err,
  output logic xfer_done,
  output logic [11:0] block_count
);

  localparam logic [14:0] WAIT_LAST = 15'(WORD_CYC - 1);

  logic [4:0] s1_q, s2_q;
  logic t_d_q;
  logic [2:0] lcnt_q;
  logic sync_q;
  logic [5:0] mk_q;
  logic [17:0] asm_q, wsh_q, next_q, rdw_q;
  logic [17:0] transfer_length_counter, transfer_pointer;
  logic [5:0] chk_q;
  logic [2:0] wbuf_q, cur_q;
  logic fin_q, par_q, req_q, blk_q, merr_q, cerr_q, terr_q, done_q;
  logic [11:0] bcnt_q;
  logic [14:0] wait_q;
  tw_pkg::tw_zone_e zone_q;
  tw_pkg::tw_chan_e ch_q;

  // Decoded strobes and modes
  wire tpos = s2_q[4] & ~t_d_q;
  wire tneg = ~s2_q[4] & t_d_q;
  wire [2:0] dat_s = s2_q[2:0];
  wire writing = op_mode == tw_pkg::MODE_WRITE;
  wire search = op_mode == tw_pkg::MODE_SEARCH;
  wire reading = search | (op_mode == tw_pkg::MODE_READ);
  wire active = op_mode != tw_pkg::MODE_IDLE;
  wire [5:0] mark_nx = {mk_q[4:0], s2_q[3]};
  wire [17:0] fword = {asm_q[14:0], dat_s};
  wire legal = tw_pkg::tw_legal(mark_nx);

  // Frame end comes from the line count once aligned
  wire frame_ev = tpos & (sync_q ? lcnt_q == tw_pkg::LAST_LINE : legal);
  wire fr = frame_ev & active;
  wire is_data = mark_nx == tw_pkg::MK_DATA;
  wire is_chk = mark_nx == tw_pkg::MK_CHECK;
  wire ent_data = fr & zone_q == tw_pkg::ZN_IBZ &
    mark_nx == tw_pkg::MK_RCHECK;
  wire word_fr = fr & zone_q == tw_pkg::ZN_DATA & (is_data | is_chk);
  wire last_fr = word_fr & is_chk & fin_q;
  wire chk_fr = fr & zone_q == tw_pkg::ZN_CHECK;
  wire word_ev = ~done_q & (reading ? word_fr :
    writing & (ent_data | (word_fr & ~last_fr)));
  wire blk_ev = ent_data | last_fr;
  wire bad_mark = frame_ev & sync_q & ~legal;
  wire odd_blk = last_fr & ~par_q;
  wire bad_chk = chk_fr & reading & fword[17:12] != chk_q;
  wire ack = mem_ack & mem_req;
  wire wload = tneg & lcnt_q == tw_pkg::LINE_RST;
  wire [17:0] wsrc = zone_q == tw_pkg::ZN_CHECK ? {chk_q, 12'h000} :
    next_q;

  // Two-flop synchronisers on every tape input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      t_d_q <= 1'b0;
    end else if (clk_en) begin
      s1_q <= {timing_trk, mark_trk, data_trk};
      s2_q <= s1_q;
      t_d_q <= s2_q[4];
    end
  end

  // Line counter; a lost frame drops sync and realigns on a legal code
  // modulo-six framing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcnt_q <= tw_pkg::LINE_RST;
      sync_q <= 1'b0;
      mk_q <= 6'h00;
    end else if (clk_en && tpos) begin
      mk_q <= mark_nx;
      lcnt_q <= frame_ev ? tw_pkg::LINE_RST : lcnt_q + 3'h1;
      sync_q <= legal | (sync_q & ~frame_ev);
    end
  end

  // Read assembly, one line per strobe, mark shifted alongside
  // strobe into buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      asm_q <= tw_pkg::WORD_RST;
      rdw_q <= tw_pkg::WORD_RST;
    end else if (clk_en && tpos && reading) begin
      asm_q <= fword;
      if (word_fr) begin
        rdw_q <= fword;
      end
    end
  end

  // Zone tracking driven by mark codes
  // blocks framed by control words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zone_q <= tw_pkg::ZN_IBZ;
      fin_q <= 1'b0;
      par_q <= 1'b0;
      bcnt_q <= tw_pkg::BLK_RST;
    end else if (clk_en) begin
      if (!active) begin
        zone_q <= tw_pkg::ZN_IBZ;
      end else if (ent_data) begin
        zone_q <= tw_pkg::ZN_DATA;
        fin_q <= 1'b0;
        par_q <= 1'b0;
        bcnt_q <= bcnt_q + 12'h001;
      end else if (word_fr) begin
        par_q <= ~par_q;
        fin_q <= is_chk;
        if (last_fr) begin
          zone_q <= tw_pkg::ZN_CHECK;
        end
      end else if (fr && zone_q == tw_pkg::ZN_DATA) begin
        zone_q <= tw_pkg::ZN_IBZ;
      end else if (chk_fr) begin
        zone_q <= tw_pkg::ZN_IBZ;
      end
    end
  end

  // Check character: seeded at block start, folded per word
  // equivalence check character
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_q <= tw_pkg::CHK_SEED;
    end else if (clk_en) begin
      if (ent_data) begin
        chk_q <= reading ? fword[17:12] : tw_pkg::CHK_SEED;
      end else if (reading && word_fr) begin
        chk_q <= tw_pkg::tw_chk_step(chk_q, fword);
      end else if (writing && wload && zone_q == tw_pkg::ZN_DATA) begin
        chk_q <= tw_pkg::tw_chk_step(chk_q, next_q);
      end
    end
  end

  // Write side; the word fetched last frame is taken at line zero
  // load next line on negative edge
  // reverse all heads on positive edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wsh_q <= tw_pkg::WORD_RST;
      wbuf_q <= 3'h0;
      cur_q <= 3'h7;
      wr_en <= 1'b0;
    end else if (clk_en && writing) begin
      if (tneg) begin
        wbuf_q <= wload ? wsrc[17:15] : wsh_q[17:15];
        wsh_q <= wload ? {wsrc[14:0], 3'h0} : {wsh_q[14:0], 3'h0};
        cur_q <= ~(wload ? wsrc[17:15] : wsh_q[17:15]);
        wr_en <= zone_q != tw_pkg::ZN_IBZ;
      end else if (tpos) begin
        cur_q <= ~cur_q;
      end
    end else if (clk_en) begin
      wr_en <= 1'b0;
    end
  end

  // Data channel cycle: count, address, then the word itself
  // channel zero cells
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_q <= tw_pkg::CH_IDLE;
      transfer_length_counter <= tw_pkg::WORD_RST;
      transfer_pointer <= tw_pkg::WORD_RST;
      next_q <= tw_pkg::WORD_RST;
      done_q <= 1'b0;
    end else if (clk_en) begin
      unique case (ch_q)
        tw_pkg::CH_IDLE: begin
          if (!active) begin
            done_q <= 1'b0;
          end else if (req_q && !done_q) begin
            ch_q <= tw_pkg::CH_RD_WC;
          end
        end
        tw_pkg::CH_RD_WC: begin
          if (ack) begin
            transfer_length_counter <= mem_rdata + 18'h00001;
            ch_q <= tw_pkg::CH_WR_WC;
          end
        end
        tw_pkg::CH_WR_WC: begin
          if (ack) begin
            ch_q <= tw_pkg::CH_RD_CA;
          end
        end
        tw_pkg::CH_RD_CA: begin
          if (ack) begin
            // search leaves the address cell alone
            transfer_pointer <= search ? mem_rdata :
              mem_rdata + 18'h00001;
            ch_q <= search ? tw_pkg::CH_DATA : tw_pkg::CH_WR_CA;
          end
        end
        tw_pkg::CH_WR_CA: begin
          if (ack) begin
            ch_q <= tw_pkg::CH_DATA;
          end
        end
        tw_pkg::CH_DATA: begin
          if (ack) begin
            if (writing) begin
              next_q <= mem_rdata;
            end
            done_q <= transfer_length_counter == tw_pkg::WORD_RST;
            ch_q <= tw_pkg::CH_IDLE;
          end
        end
      endcase
    end
  end

  // Request flag and the per-word deadline; a set beats the ack
  // word request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      wait_q <= 15'h0000;
    end else if (clk_en) begin
      req_q <= word_ev | (req_q & ~(ch_q == tw_pkg::CH_DATA & ack));
      wait_q <= (req_q && wait_q != WAIT_LAST) ? wait_q + 15'h0001 :
        (req_q ? wait_q : 15'h0000);
    end
  end

  // Sticky flags; clear is a level, any new event wins over it
  // block boundary flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_q <= 1'b0;
      merr_q <= 1'b0;
      cerr_q <= 1'b0;
      terr_q <= 1'b0;
    end else if (clk_en) begin
      blk_q <= blk_ev | (blk_q & ~flag_clr);
      merr_q <= bad_mark | odd_blk | (merr_q & ~flag_clr);
      cerr_q <= bad_chk | (cerr_q & ~flag_clr);
      terr_q <= (req_q & wait_q == WAIT_LAST) | (terr_q & ~flag_clr);
    end
  end

  // Channel outputs decoded from the state
  assign mem_req = ch_q != tw_pkg::CH_IDLE;
  assign mem_we = ch_q == tw_pkg::CH_WR_WC || ch_q == tw_pkg::CH_WR_CA ||
    (ch_q == tw_pkg::CH_DATA && !writing);
  assign mem_addr = (ch_q == tw_pkg::CH_RD_WC || ch_q == tw_pkg::CH_WR_WC)
    ? tw_pkg::WC_CELL : (ch_q == tw_pkg::CH_DATA ? transfer_pointer[14:0]
    : tw_pkg::CA_CELL);
  assign mem_wdata = ch_q == tw_pkg::CH_WR_WC ? transfer_length_counter :
    (ch_q == tw_pkg::CH_WR_CA ? transfer_pointer : rdw_q);

  // Status outputs
  assign wr_cur = cur_q;
  assign word_request_flag = req_q;
  assign block_boundary_flag = blk_q;
  assign mark_err = merr_q;
  assign check_err = cerr_q;
  assign timing_err = terr_q;
  assign xfer_done = done_q;
  assign block_count = bcnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_req_word;
    clk_en && word_ev |=> req_q;
  endproperty
  a_req_word: assert property (p_req_word) else $error("request lost");

  property p_blk_flag;
    clk_en && blk_ev |=> blk_q;
  endproperty
  a_blk_flag: assert property (p_blk_flag) else $error("boundary lost");

  property p_mark_err;
    clk_en && bad_mark |=> merr_q;
  endproperty
  a_mark_err: assert property (p_mark_err) else $error("bad mark missed");

  property p_wrap;
    clk_en && tpos && sync_q && lcnt_q == 3'h5 |=> lcnt_q == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("line count no wrap");

  property p_wc_inc;
    clk_en && ch_q == tw_pkg::CH_RD_WC && ack
      |=> transfer_length_counter == $past(mem_rdata) + 18'h00001;
  endproperty
  a_wc_inc: assert property (p_wc_inc) else $error("count not stepped");

  property p_ca_search;
    clk_en && search && ch_q == tw_pkg::CH_RD_CA && ack
      |=> transfer_pointer == $past(mem_rdata) && ch_q == tw_pkg::CH_DATA;
  endproperty
  a_ca_search: assert property (p_ca_search) else $error("search stepped");

  property p_last;
    clk_en && ch_q == tw_pkg::CH_DATA && ack &&
      transfer_length_counter == 18'h00000 |=> done_q ##1 !mem_req;
  endproperty
  a_last: assert property (p_last) else $error("ran past overflow");

  property p_flip;
    clk_en && writing && tpos |=> cur_q == ~$past(cur_q);
  endproperty
  a_flip: assert property (p_flip) else $error("heads not reversed");

  property p_load;
    clk_en && writing && tneg |=> cur_q == ~wbuf_q;
  endproperty
  a_load: assert property (p_load) else $error("write line not set");

  property p_strobe;
    clk_en && reading && tpos |=> asm_q[2:0] == $past(dat_s);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe wrong");

endmodule
`default_nettype wire

// File: bench/tw_tape_model.sv
`timescale 1ns/100ps
`default_nettype none
module tw_tape_model (
  // Read amplifiers
  output logic timing_trk,
  output logic mark_trk,
  output logic [2:0] data_trk,
  // Write heads
  input wire logic [2:0] wr_cur,
  input wire logic wr_en
);
  logic [2:0] wq [$];
  int bad_pol;

  // Lines idle low until the first frame
  initial begin
    timing_trk = 1'b0;
    mark_trk = 1'b0;
    data_trk = 3'h0;
    bad_pol = 0;
  end

  // Six lines of one frame; timing rests low between frames.
  // The high phase is long so that the channel can fetch a write word
  // after a frame end, before the fall that loads its first line.
  task automatic frame(input logic [5:0] mk, input logic [17:0] w);
    logic [2:0] pre;
    logic en;
    for (int i = 0; i < 6; i++) begin
      data_trk = w[17-3*i -: 3];
      mark_trk = mk[5-i];
      #31.25;
      pre = wr_cur;
      en = wr_en;
      timing_trk = 1'b1;
      #60;
      if (en && pre !== ~wr_cur) bad_pol++;
      if (en) wq.push_back(wr_cur);
      #32.5;
      timing_trk = 1'b0;
      #1.25;
    end
    // Released lines no longer hold their last value
    data_trk = ~data_trk;
    mark_trk = ~mark_trk;
  endtask
endmodule
`default_nettype wire

// File: bench/tw_datapath_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tw_datapath_bench;
  logic clk, rst_n, flag_clr, mem_ack, fast, ack_d;
  logic [1:0] op_mode;
  logic [17:0] mem_rdata, mem_wdata;
  logic [17:0] mem [0:511];
  logic [17:0] wd [4];
  logic [5:0] ck;
  logic [77:0] lines;
  logic [14:0] mem_addr;
  logic [11:0] block_count;
  logic [2:0] data_trk, wr_cur;
  logic timing_trk, mark_trk, wr_en, mem_req, mem_we;
  logic bbf, mark_err, check_err, timing_err, xfer_done, wrf, wrf_d;
  int err_total, samples_checked, nreq;
  int unsigned seed;

  tw_datapath #(.WORD_CYC(200)) tw_datapath_i (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .op_mode(op_mode),
    .flag_clr(flag_clr), .timing_trk(timing_trk), .mark_trk(mark_trk),
    .data_trk(data_trk), .wr_cur(wr_cur), .wr_en(wr_en),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .word_request_flag(wrf), .block_boundary_flag(bbf),
    .mark_err(mark_err), .check_err(check_err), .timing_err(timing_err),
    .xfer_done(xfer_done), .block_count(block_count));

  tw_tape_model tw_tape_model_i (
    .timing_trk(timing_trk), .mark_trk(mark_trk), .data_trk(data_trk),
    .wr_cur(wr_cur), .wr_en(wr_en));

  always #5 clk = ~clk;

  // Memory answers at the falling edge, late at random unless fast.
  // Fast mode acks every cycle: a write word must land within a line.
  always @(negedge clk) begin
    ack_d = mem_req && (fast || (!mem_ack && $urandom_range(1, 0) == 1));
    mem_rdata <= ack_d ? mem[mem_addr[8:0]] : ~mem_rdata;
    mem_ack <= ack_d;
  end

  // Rising edges of the word request flag, seen where it is settled
  always @(negedge clk) begin
    wrf_d <= wrf;
    if (wrf && !wrf_d) nreq++;
  end

  // Writes land at the edge that takes the ack
  always @(posedge clk) begin
    if (mem_req && mem_ack && mem_we) mem[mem_addr[8:0]] <= mem_wdata;
  end

  task automatic check(input string nm, input logic [17:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Channel cells hold the negated count and first address minus one
  task automatic prep();
    mem[30] = 18'h3FFFC;
    mem[31] = 18'h000FF;
  endtask

  // One block of four words; expected check kept from the rule
  task automatic block(input logic [1:0] md, input logic bad);
    logic [17:0] sd;
    @(negedge clk);
    op_mode = md;
    nreq = 0;
    fast = md == tw_pkg::MODE_WRITE;
    sd = 18'($urandom);
    ck = fast ? 6'h00 : sd[17:12];
    for (int k = 0; k < 4; k++) begin
      wd[k] = fast ? mem[256+k] : 18'($urandom);
      for (int g = 2; g >= 0; g--) ck = ~(ck ^ wd[k][6*g +: 6]);
    end
    repeat (3) tw_tape_model_i.frame(tw_pkg::MK_IBZ, 18'($urandom));
    tw_tape_model_i.frame(tw_pkg::MK_RCHECK, sd);
    for (int k = 0; k < 4; k++) begin
      tw_tape_model_i.frame(k < 2 ? tw_pkg::MK_DATA : tw_pkg::MK_CHECK,
        wd[k]);
    end
    tw_tape_model_i.frame(tw_pkg::MK_CHECK,
      {ck ^ {6{bad}}, 12'($urandom)});
    repeat (2) tw_tape_model_i.frame(tw_pkg::MK_IBZ, 18'($urandom));
  endtask

  // Back to idle and clear the sticky flags
  task automatic clear();
    @(negedge clk);
    op_mode = tw_pkg::MODE_IDLE;
    flag_clr = 1'b1;
    @(negedge clk);
    flag_clr = 1'b0;
    @(negedge clk);
    check("done idle", 18'h0, 18'(xfer_done));
    check("flags", 18'h0, 18'({bbf, mark_err, check_err}));
  endtask

  // Cut a hang short
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    flag_clr = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = 18'h00000;
    op_mode = tw_pkg::MODE_IDLE;
    fast = 1'b0;
    err_total = 0;
    samples_checked = 0;
    nreq = 0;
    for (int i = 0; i < 512; i++) mem[i] = 18'h00000;
    seed = $urandom(32'h6c09653c);
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    // Read: four words land in order, cells stepped
    prep();
    block(tw_pkg::MODE_READ, 1'b0);
    for (int k = 0; k < 4; k++) check("word", wd[k], mem[256+k]);
    check("count cell", 18'h00000, mem[30]);
    check("address cell", 18'h00103, mem[31]);
    check("done", 18'h1, 18'(xfer_done));
    check("boundary", 18'h1, 18'(bbf));
    check("check err", 18'h0, 18'(check_err));
    check("mark err", 18'h0, 18'(mark_err));
    check("timing err", 18'h0, 18'(timing_err));
    check("requests", 18'h4, 18'(nreq));
    check("request idle", 18'h0, 18'(wrf));
    clear();
    // Read with a spoiled check, then an illegal mark
    prep();
    block(tw_pkg::MODE_READ, 1'b1);
    tw_tape_model_i.frame(6'h00, 18'h00000);
    check("bad check", 18'h1, 18'(check_err));
    check("bad mark", 18'h1, 18'(mark_err));
    clear();
    // Search leaves the address cell alone
    prep();
    block(tw_pkg::MODE_SEARCH, 1'b0);
    check("search address", 18'h000FF, mem[31]);
    check("search count", 18'h00000, mem[30]);
    clear();
    // Write: lines on the heads, then the check character
    for (int k = 0; k < 4; k++) mem[256+k] = 18'($urandom);
    prep();
    block(tw_pkg::MODE_WRITE, 1'b0);
    lines = {wd[0], wd[1], wd[2], wd[3], ck};
    for (int k = 0; k < 26; k++) begin
      check("line", 18'(lines[77-3*k -: 3]),
        18'(tw_tape_model_i.wq[k]));
    end
    check("polarity", 18'h0, 18'(tw_tape_model_i.bad_pol));
    check("blocks", 18'h4, 18'(block_count));
    check("write requests", 18'h4, 18'(nreq));
    clear();
    final_report();
  end
endmodule
`default_nettype wire
